// ### tsp_host_port.sv
// host register port and dual-function pcm pin logic of the switch
// Function
// R1: register_window_select high routes accesses to the indirect registers.
// R2: window select low: writes load mode register, reads return status.
// R3: processor drives chip select low; device acts only while selected.
// R4: read strobe sampled only while selected; ignored otherwise.
// R5: read strobe falling edge puts selected register on 8-bit bus.
// R6: line-3 pin is pcm input standard, 2048-kHz clock out primary.
// R7: lines 0,4,8,12 pcm inputs standard, driver enables in primary.
// R8: frame and channel timing aligned by the frame sync pulse.
// R9: write strobe sampled while selected; rising edge loads selected reg.
// R10: bus drivers stay off except during selected read strobe.
`timescale 1ns/1ns
module tsp_host_port (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic chip_sel_n,
  input wire logic register_window_select,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [tsp_pkg::DW-1:0] host_bus_0_to_7_i,
  output tsp_pkg::tsp_bus_out_t host_bus_0_to_7_o,
  input wire logic frame_sync_pulse,
  input wire logic pcm_rx3_or_bitclk_out_i,
  output tsp_pkg::tsp_pin_out_t pcm_rx3_or_bitclk_out_o,
  input wire logic pcm_rx0_or_drv_en0_i,
  output tsp_pkg::tsp_pin_out_t pcm_rx0_or_drv_en0_o,
  input wire logic pcm_rx4_or_drv_en1_i,
  output tsp_pkg::tsp_pin_out_t pcm_rx4_or_drv_en1_o,
  input wire logic pcm_rx8_or_drv_en2_i,
  output tsp_pkg::tsp_pin_out_t pcm_rx8_or_drv_en2_o,
  input wire logic pcm_rx12_or_drv_en3_i,
  output tsp_pkg::tsp_pin_out_t pcm_rx12_or_drv_en3_o,
  output logic [tsp_pkg::RX_LINES-1:0] pcm_rx_data,
  output logic primary_mode,
  output logic [tsp_pkg::FRAME_BITS_W-1:0] frame_bit_pos
);
  import tsp_pkg::*;

  localparam int SW = 5 + DW + RX_LINES;

  // pin synchronisers: a bit moves once stages two and three agree
  logic [SW-1:0] raw;
  logic [SW-1:0] s1_ff, s2_ff, s3_ff, flt_ff;
  logic [SW-1:0] nxt_s1, nxt_s2, nxt_s3, nxt_flt;

  always_comb begin
    raw = {chip_sel_n, register_window_select, rd_n, wr_n,
           frame_sync_pulse, host_bus_0_to_7_i,
           pcm_rx12_or_drv_en3_i, pcm_rx8_or_drv_en2_i,
           pcm_rx4_or_drv_en1_i, pcm_rx3_or_bitclk_out_i,
           pcm_rx0_or_drv_en0_i};
    nxt_s1 = raw;
    nxt_s2 = s1_ff;
    nxt_s3 = s2_ff;
    nxt_flt = flt_ff;
    for (int i = 0; i < SW; i++) begin
      if (s2_ff[i] == s3_ff[i]) begin
        nxt_flt[i] = s3_ff[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s1_ff <= '1;
      s2_ff <= '1;
      s3_ff <= '1;
      flt_ff <= '1;
    end else begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
      s3_ff <= nxt_s3;
      flt_ff <= nxt_flt;
    end
  end

  logic cs_n_f, a0_f, rd_n_f, wr_n_f, sp_f;
  logic [DW-1:0] bus_f;
  logic [RX_LINES-1:0] rx_f;

  always_comb begin
    {cs_n_f, a0_f, rd_n_f, wr_n_f, sp_f, bus_f, rx_f} = flt_ff;
  end

  // access decode: strobe edges count only while selected
  logic rd_n_q_ff, wr_n_q_ff, sp_q_ff;
  logic nxt_rd_n_q, nxt_wr_n_q, nxt_sp_q;
  logic selected, rd_fall, wr_rise, sp_rise;

  always_comb begin
    nxt_rd_n_q = rd_n_f;
    nxt_wr_n_q = wr_n_f;
    nxt_sp_q = sp_f;
    selected = !cs_n_f; // R3
    rd_fall = selected && rd_n_q_ff && !rd_n_f; // R4
    wr_rise = selected && !wr_n_q_ff && wr_n_f; // R9
    sp_rise = !sp_q_ff && sp_f;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_n_q_ff <= 1'b1;
      wr_n_q_ff <= 1'b1;
      // matches the filter's reset level, so reset gives no false sync edge
      sp_q_ff <= 1'b1;
    end else begin
      rd_n_q_ff <= nxt_rd_n_q;
      wr_n_q_ff <= nxt_wr_n_q;
      sp_q_ff <= nxt_sp_q;
    end
  end

  // mode register, indirect pointer and indirect store
  logic [DW-1:0] mode_ff, nxt_mode;
  logic [IND_AW-1:0] ptr_ff, nxt_ptr;
  logic ind_we;
  logic [DW-1:0] ind_rdata;

  always_comb begin
    nxt_mode = mode_ff;
    nxt_ptr = ptr_ff;
    ind_we = 1'b0;
    if (wr_rise) begin // R9
      if (!a0_f) begin
        nxt_mode = bus_f; // R2
      end else if (mode_ff[MODE_PTR_SEL]) begin
        nxt_ptr = bus_f[IND_AW-1:0]; // R1
      end else begin
        ind_we = 1'b1; // R1
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_ff <= MODE_RST;
      ptr_ff <= '0;
    end else begin
      mode_ff <= nxt_mode;
      ptr_ff <= nxt_ptr;
    end
  end

  // the pointer is held steady across an access, so the registered
  // read of the store is settled well before the read strobe edge
  tsp_ind_mem #(
    .AW(IND_AW),
    .DW(DW)
  ) i_tsp_ind_mem (
    .core_clk(core_clk),
    .rst(rst),
    .we(ind_we),
    .addr(ptr_ff),
    .wdata(bus_f),
    .rdata_ff(ind_rdata)
  );

  // frame timing: bit clock from a phase accumulator, frame sync
  // restarts the bit position
  logic [NCO_W-1:0] nco_ff, nxt_nco;
  logic bitclk_ff, nxt_bitclk;
  logic [FRAME_BITS_W-1:0] pos_ff, nxt_pos;
  logic aligned_ff, nxt_aligned;
  logic [NCO_W:0] nco_sum;

  always_comb begin
    nco_sum = {1'b0, nco_ff} + {1'b0, NCO_STEP};
    nxt_nco = nco_sum[NCO_W-1:0];
    nxt_bitclk = bitclk_ff;
    nxt_pos = pos_ff;
    nxt_aligned = aligned_ff;
    if (nco_sum[NCO_W]) begin
      nxt_bitclk = !bitclk_ff;
      if (bitclk_ff) begin
        nxt_pos = pos_ff + FRAME_BITS_W'(1);
      end
    end
    if (sp_rise) begin // R8
      nxt_nco = '0;
      nxt_bitclk = 1'b0;
      nxt_pos = '0;
      nxt_aligned = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      nco_ff <= '0;
      bitclk_ff <= 1'b0;
      pos_ff <= '0;
      aligned_ff <= 1'b0;
    end else begin
      nco_ff <= nxt_nco;
      bitclk_ff <= nxt_bitclk;
      pos_ff <= nxt_pos;
      aligned_ff <= nxt_aligned;
    end
  end

  // read path and bus driver
  logic [DW-1:0] status;
  logic [DW-1:0] rdata_ff, nxt_rdata;

  always_comb begin
    status = '0;
    status[STAT_PRIMARY] = mode_ff[MODE_PRIMARY];
    status[STAT_ALIGNED] = aligned_ff;
    status[STAT_PTR_SEL] = mode_ff[MODE_PTR_SEL];
    status[DW-1:STAT_CHAN_LO] = pos_ff[FRAME_BITS_W-1:3];
    nxt_rdata = rdata_ff;
    if (rd_fall) begin // R5
      if (!a0_f) begin
        nxt_rdata = status; // R2
      end else if (mode_ff[MODE_PTR_SEL]) begin
        nxt_rdata = {{(DW-IND_AW){1'b0}}, ptr_ff}; // R1
      end else begin
        nxt_rdata = ind_rdata; // R1
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // drive only while a selected read strobe is low; the enable follows
  // the filtered strobe, so it turns on with the captured data
  always_comb begin
    host_bus_0_to_7_o.data = rdata_ff; // R5
    host_bus_0_to_7_o.oe = selected && !rd_n_f && !rd_n_q_ff; // R10
  end

  // dual-function pins
  logic prim;
  logic [DRV_LINES-1:0] drv;

  always_comb begin
    prim = mode_ff[MODE_PRIMARY];
    drv = mode_ff[MODE_DRV_HI:MODE_DRV_LO] & {DRV_LINES{aligned_ff}};
    primary_mode = prim;
    frame_bit_pos = pos_ff;
    pcm_rx_data = rx_f;
    pcm_rx3_or_bitclk_out_o.o = bitclk_ff; // R6
    pcm_rx3_or_bitclk_out_o.oe = prim; // R6
    pcm_rx0_or_drv_en0_o.o = drv[0]; // R7
    pcm_rx0_or_drv_en0_o.oe = prim; // R7
    pcm_rx4_or_drv_en1_o.o = drv[1];
    pcm_rx4_or_drv_en1_o.oe = prim;
    pcm_rx8_or_drv_en2_o.o = drv[2];
    pcm_rx8_or_drv_en2_o.oe = prim;
    pcm_rx12_or_drv_en3_o.o = drv[3];
    pcm_rx12_or_drv_en3_o.oe = prim;
  end
endmodule : tsp_host_port

// ### tsp_pkg.sv
// package: constants and carrier types for the switch host port and pins
package tsp_pkg;
  localparam int CLK_KHZ = 125000;
  localparam int BITCLK_KHZ = 2048;
  localparam int NCO_W = 16;
  // phase step giving one overflow per bit-clock half period
  localparam logic [NCO_W-1:0] NCO_STEP =
    NCO_W'((2 * BITCLK_KHZ * 65536) / CLK_KHZ);
  localparam int FRAME_BITS_W = 8;
  localparam int SYNC_STAGES = 3;
  localparam int IND_AW = 4;
  localparam int DW = 8;
  // mode register fields
  localparam int MODE_PRIMARY = 0;
  localparam int MODE_PTR_SEL = 1;
  localparam int MODE_DRV_LO = 2;
  localparam int MODE_DRV_HI = 5;
  localparam logic [7:0] MODE_RST = 8'h00;
  // status register fields, then pcm input and driver-enable line counts
  localparam int STAT_PRIMARY = 0;
  localparam int STAT_ALIGNED = 1;
  localparam int STAT_PTR_SEL = 2;
  localparam int STAT_CHAN_LO = 3;
  localparam int RX_LINES = 5;
  localparam int DRV_LINES = 4;

  typedef struct packed {
    logic o;
    logic oe;
  } tsp_pin_out_t;

  typedef struct packed {
    logic [DW-1:0] data;
    logic oe;
  } tsp_bus_out_t;
endpackage : tsp_pkg

// ### tsp_ind_mem.sv
// small indirect register store with registered read data
`timescale 1ns/1ns
module tsp_ind_mem #(
  parameter int AW = 4,
  parameter int DW = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata_ff
);
  logic [DW-1:0] mem [2**AW];
  logic [DW-1:0] nxt_rdata;

  always_comb begin
    nxt_rdata = mem[addr];
  end

  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    if (rst) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end
endmodule : tsp_ind_mem

// ### tsp_host_port_checker.sv
// assertions on the host port and pin outputs
`timescale 1ns/1ns
module tsp_host_port_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic chip_sel_n,
  input wire logic rd_n,
  input wire logic frame_sync_pulse,
  input tsp_pkg::tsp_bus_out_t host_bus_0_to_7_o,
  input tsp_pkg::tsp_pin_out_t pcm_rx3_or_bitclk_out_o,
  input tsp_pkg::tsp_pin_out_t pcm_rx0_or_drv_en0_o,
  input wire logic primary_mode,
  input wire logic [tsp_pkg::FRAME_BITS_W-1:0] frame_bit_pos
);
  import tsp_pkg::*;
  wire oe = host_bus_0_to_7_o.oe;
  wire c3 = pcm_rx3_or_bitclk_out_o.o;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // four cycles back covers the pin filter: three synchroniser flops and the filter flop
  property p_off; oe |-> !$past(rd_n, 4) && !$past(chip_sel_n, 4); endproperty
  a_off: assert property (p_off) else $error("bus driven");
  property p_ans; $fell(rd_n) && !chip_sel_n |-> ##[3:7] oe; endproperty
  a_ans: assert property (p_ans) else $error("no read data");
  property p_hold; oe && $past(oe) |-> $stable(host_bus_0_to_7_o.data);
  endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  property p_cke; pcm_rx3_or_bitclk_out_o.oe == primary_mode; endproperty
  a_cke: assert property (p_cke) else $error("clock pin role");
  property p_ckr; primary_mode && c3 |-> ##[1:33] !c3; endproperty
  a_ckr: assert property (p_ckr) else $error("clock stuck");
  property p_den; pcm_rx0_or_drv_en0_o.oe == primary_mode; endproperty
  a_den: assert property (p_den) else $error("enable pin role");
  property p_mod; $changed(primary_mode) |-> !$past(chip_sel_n, 4); endproperty
  a_mod: assert property (p_mod) else $error("mode w/o select");
  property p_syn; $rose(frame_sync_pulse) |-> ##[3:6] frame_bit_pos == 8'h00;
  endproperty
  a_syn: assert property (p_syn) else $error("no align");
  cover property ($rose(oe));
  cover property ($rose(primary_mode));
  cover property ($rose(frame_sync_pulse));
endmodule : tsp_host_port_checker
bind tsp_host_port tsp_host_port_checker i_chk (.core_clk, .rst,
  .chip_sel_n, .rd_n, .frame_sync_pulse, .host_bus_0_to_7_o,
  .pcm_rx3_or_bitclk_out_o, .pcm_rx0_or_drv_en0_o, .primary_mode,
  .frame_bit_pos);

// ### tsp_cpu_model.sv
// processor model driving the host port strobes and data bus
`timescale 1ns/1ns
module tsp_cpu_model (
  input wire logic core_clk,
  input tsp_pkg::tsp_bus_out_t bus_in,
  output logic chip_sel_n,
  output logic register_window_select,
  output logic rd_n,
  output logic wr_n,
  output logic [tsp_pkg::DW-1:0] bus_out
);
  import tsp_pkg::*;
  initial begin
    chip_sel_n = 1'b1;
    register_window_select = 1'b0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    bus_out = 8'h00;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic xfer(input logic sel, input logic a0, input logic wr,
    input logic [7:0] d, output logic [7:0] q);
    chip_sel_n = ~sel;
    register_window_select = a0;
    bus_out = d;
    cyc(4);
    rd_n = wr;
    wr_n = ~wr;
    for (int i = 0; i < 12 && sel && !wr && bus_in.oe !== 1'b1; i++)
      cyc(1);
    q = bus_in.data;
    cyc(6);
    rd_n = 1'b1;
    wr_n = 1'b1;
    cyc(6);
    chip_sel_n = 1'b1;
    // released lines flip so stale values cannot pass
    register_window_select = ~a0;
    bus_out = ~d;
    cyc(4);
  endtask : xfer
endmodule : tsp_cpu_model

// ### tsp_host_port_tb.sv
// self-checking bench for the switch host port and pins
`timescale 1ns/1ns
module tsp_host_port_tb;
  import tsp_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic frame_sync_pulse = 1'b0;
  logic [4:0] pins = 5'h0d;
  logic chip_sel_n, register_window_select, rd_n, wr_n, primary_mode;
  logic [7:0] cpu_d, bus_w, frame_bit_pos;
  logic [4:0] rx_w, pcm_rx_data;
  tsp_bus_out_t bo;
  tsp_pin_out_t p0, p3, p4, p8, p12;
  int err_count = 0;
  int checked = 0;
  assign bus_w = bo.oe ? bo.data : cpu_d;
  assign rx_w = {p12.oe ? p12.o : pins[4], p8.oe ? p8.o : pins[3],
    p4.oe ? p4.o : pins[2], p3.oe ? p3.o : pins[1], p0.oe ? p0.o : pins[0]};
  tsp_host_port i_tsp_host_port (.core_clk, .rst, .chip_sel_n,
    .register_window_select, .rd_n, .wr_n, .host_bus_0_to_7_i(bus_w),
    .host_bus_0_to_7_o(bo), .frame_sync_pulse,
    .pcm_rx3_or_bitclk_out_i(rx_w[1]), .pcm_rx3_or_bitclk_out_o(p3),
    .pcm_rx0_or_drv_en0_i(rx_w[0]), .pcm_rx0_or_drv_en0_o(p0),
    .pcm_rx4_or_drv_en1_i(rx_w[2]), .pcm_rx4_or_drv_en1_o(p4),
    .pcm_rx8_or_drv_en2_i(rx_w[3]), .pcm_rx8_or_drv_en2_o(p8),
    .pcm_rx12_or_drv_en3_i(rx_w[4]), .pcm_rx12_or_drv_en3_o(p12),
    .pcm_rx_data, .primary_mode, .frame_bit_pos);
  tsp_cpu_model u_cpu (.core_clk, .bus_in(bo), .chip_sel_n,
    .register_window_select, .rd_n, .wr_n, .bus_out(cpu_d));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic finish_test();
    if (err_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : wt
  task automatic wr(input logic a, input logic [7:0] d);
    logic [7:0] q;
    u_cpu.xfer(1'b1, a, 1'b1, d, q);
  endtask : wr
  task automatic rd(input logic a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] q;
    u_cpu.xfer(1'b1, a, 1'b0, 8'h00, q);
    chk(q & m, e);
  endtask : rd
  task automatic t_std();
    rd(1'b0, 8'h07, 8'h00);
    chk({3'h0, pcm_rx_data}, {3'h0, pins});
    chk({3'h0, p0.oe, p3.oe, p4.oe, p8.oe, p12.oe}, 8'h00);
  endtask : t_std
  task automatic t_desel();
    logic [7:0] q;
    u_cpu.xfer(1'b0, 1'b0, 1'b1, 8'h01, q);
    u_cpu.xfer(1'b0, 1'b0, 1'b0, 8'h00, q);
    chk({7'h0, primary_mode}, 8'h00);
  endtask : t_desel
  task automatic t_mode();
    wr(1'b0, 8'h3d);
    chk({7'h0, primary_mode}, 8'h01);
    chk({3'h0, p0.oe, p3.oe, p4.oe, p8.oe, p12.oe}, 8'h1f);
    chk({7'h0, p0.o}, 8'h00);
    rd(1'b0, 8'h07, 8'h01);
    frame_sync_pulse = 1'b1;
    wt(6);
    frame_sync_pulse = 1'b0;
    wt(6);
    chk({4'h0, p0.o, p4.o, p8.o, p12.o}, 8'h0f);
    chk(frame_bit_pos, 8'h00);
    chk({7'h0, p3.o}, 8'h00);
    wt(30);
    chk({7'h0, p3.o}, 8'h01);
    rd(1'b0, 8'h07, 8'h03);
  endtask : t_mode
  task automatic setp(input logic [7:0] p);
    wr(1'b0, 8'h02);
    wr(1'b1, p);
    wr(1'b0, 8'h00);
  endtask : setp
  task automatic t_ind();
    setp(8'h05);
    wr(1'b1, 8'ha5);
    chk({7'h0, primary_mode}, 8'h00);
    setp(8'h06);
    wr(1'b1, 8'h3c);
    setp(8'h05);
    rd(1'b1, 8'hff, 8'ha5);
    setp(8'h06);
    rd(1'b1, 8'hff, 8'h3c);
    wr(1'b0, 8'h02);
    rd(1'b1, 8'hff, 8'h06);
  endtask : t_ind
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    #100000;
    err_count++;
    finish_test();
  end
  initial begin
    wt(5);
    rst = 1'b0;
    wt(6);
    t_std();
    t_desel();
    t_mode();
    t_ind();
    finish_test();
  end
endmodule : tsp_host_port_tb
